// *** design/acg_params.svh ***
/*
 * Offsets, field positions, reset values and code limits for the
 * channel gain configuration registers.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef ACG_PARAMS_SVH
`define ACG_PARAMS_SVH

`define ACG_PAGE_CFG          8'h00
`define ACG_OFS_INPUT_GAIN    8'h4C
`define ACG_OFS_DIG_VOLUME    8'h4D
`define ACG_OFS_GAIN_TRIM     8'h4E
`define ACG_OFS_PHASE_DELAY   8'h4F
`define ACG_OFS_NEXT_VOLUME   8'h52

`define ACG_RST_INPUT_GAIN    8'h00
`define ACG_RST_DIG_VOLUME    8'hC9
`define ACG_RST_GAIN_TRIM     8'h80
`define ACG_RST_PHASE_DELAY   8'h00
`define ACG_RST_NEXT_VOLUME   8'hC9

`define ACG_GAIN_MSB          7
`define ACG_GAIN_LSB          2
`define ACG_TRIM_MSB          7
`define ACG_TRIM_LSB          4

`define ACG_GAIN_MAX_CODE     6'h2A
`define ACG_VOL_MUTE_CODE     8'h00
`define ACG_VOL_UNITY_CODE    9'h0C9
`define ACG_TRIM_UNITY_CODE   5'h08
`define ACG_DELAY_DEPTH       256

`endif

// *** design/acg_phase_delay.sv ***
/*
 * Modulator-rate delay line for one channel bitstream.
 * Assumes mod_en_i pulses once per modulator clock cycle and that
 * the delay code is stable while the stream is in use.
 */
`timescale 1ns/1ps
`include "acg_params.svh"
module acg_phase_delay
   import acg_pkg::*;
#(
   parameter int DEPTH = `ACG_DELAY_DEPTH
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       mod_en_i,
   input  wire logic       bit_i,
   input  wire logic [7:0] delay_cycles_i,
   output logic            bit_o
);

   logic [DEPTH-1:0] hist_q;
   logic [DEPTH-1:0] hist_d;
   logic             bit_q;
   logic             bit_d;

   always_comb begin
      hist_d = hist_q;
      bit_d  = bit_q;
      if (mod_en_i) begin
         hist_d = {hist_q[DEPTH-2:0], bit_i};
         // RULE9 zero code bypass
         if (delay_cycles_i == 8'h00) begin
            bit_d = bit_i;
         end else begin
            // RULE8 tap per cycle
            bit_d = hist_q[delay_cycles_i - 8'h01];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hist_q <= '0;
         bit_q  <= 1'b0;
      end else begin
         hist_q <= hist_d;
         bit_q  <= bit_d;
      end
   end

   assign bit_o = bit_q;

endmodule

// *** design/acg_pkg.sv ***
/*
 * Types shared by the channel gain configuration block.
 * Assumes acg_params.svh is on the include path.
 */
package acg_pkg;
`include "acg_params.svh"

   // Register access request from the control port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acg_req_t;

   // Decoded channel settings presented to the signal path
   typedef struct packed {
      logic [5:0]        gain_db;
      logic              gain_reserved;
      logic signed [8:0] volume_half_db;
      logic              muted;
      logic signed [4:0] trim_tenth_db;
      logic [7:0]        delay_cycles;
   } acg_cfg_t;

   typedef enum logic [2:0] {
      ACG_SEL_NONE,
      ACG_SEL_GAIN,
      ACG_SEL_VOLUME,
      ACG_SEL_TRIM,
      ACG_SEL_DELAY,
      ACG_SEL_NEXT_VOL
   } acg_sel_t;

endpackage

// *** design/acg_regs.sv ***
/*
 * Configuration register set of one audio input channel, plus the
 * digital volume of the following channel, with the decoded settings
 * and a simple mute / phase-delay signal path.
 * Assumes a register access port on control page zero, synchronous
 * inputs on core_clk_i and a modulator-rate enable from a divider.
 */
`timescale 1ns/1ps
`include "acg_params.svh"

// Behaviour
// RULE1: Gain field bits 7..2; codes 0..42 give that many dB.
// RULE2: Software must not write gain codes 43..63; they are reserved.
// RULE3: Volume code zero mutes the digital output completely. The code zeroes sample_o only; mod_bit_o still passes the delayed bitstream.
// RULE4: Volume codes 1..255 in 0.5 dB steps; 201 is unity.
// RULE5: Volume register resets to C9, read and write.
// RULE6: Trim field bits 7..4 in 0.1 dB steps; code 8 is 0 dB.
// RULE7: Trim register resets to 80; low four bits read zero.
// RULE8: Phase code delays channel by that many modulator cycles.
// RULE9: Phase code zero gives no delay; register resets to zero.
// RULE10: Phase register lives at page zero address 4F, read and write.
// RULE11: Next channel volume at 52, reset C9, for digital mics only.
// RULE12: Gain register lives at page zero address 4C, resets to zero.
// RULE13: Reserved bits read zero and ignore written values.
module acg_regs
   import acg_pkg::*;
#(
   parameter int SAMPLE_W = 24
) (
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   input  wire acg_req_t            req_i,
   output logic [7:0]               rdata_o,
   output logic                     rvalid_o,
   output logic                     hit_o,
   input  wire logic                pulse_density_mic_input_i,
   input  wire logic                mod_en_i,
   input  wire logic                mod_bit_i,
   output logic                     mod_bit_o,
   input  wire logic                sample_valid_i,
   input  wire logic [SAMPLE_W-1:0] sample_i,
   output logic                     sample_valid_o,
   output logic [SAMPLE_W-1:0]      sample_o,
   output acg_cfg_t                 cfg_o,
   output logic signed [8:0]        next_volume_half_db_o,
   output logic                     next_muted_o,
   output logic                     next_volume_active_o
);

   // RULE4 half-dB decode
   function automatic logic signed [8:0] vol_half_db(
      input logic [7:0] code
   );
      vol_half_db = $signed({1'b0, code}) - $signed(`ACG_VOL_UNITY_CODE);
   endfunction

   // Reserved or foreign pages fall to NONE
   function automatic acg_sel_t decode(input logic [7:0] page,
                                       input logic [7:0] addr);
      decode = ACG_SEL_NONE;
      if (page == `ACG_PAGE_CFG) begin
         case (addr)
            `ACG_OFS_INPUT_GAIN:  decode = ACG_SEL_GAIN;
            `ACG_OFS_DIG_VOLUME:  decode = ACG_SEL_VOLUME;
            `ACG_OFS_GAIN_TRIM:   decode = ACG_SEL_TRIM;
            `ACG_OFS_PHASE_DELAY: decode = ACG_SEL_DELAY;
            `ACG_OFS_NEXT_VOLUME: decode = ACG_SEL_NEXT_VOL;
            default:              decode = ACG_SEL_NONE;
         endcase
      end
   endfunction

   logic [5:0] input_gain_code_q;
   logic [5:0] input_gain_code_d;
   logic [7:0] digital_volume_code_q;
   logic [7:0] digital_volume_code_d;
   logic [3:0] gain_trim_code_q;
   logic [3:0] gain_trim_code_d;
   logic [7:0] phase_delay_cycles_q;
   logic [7:0] phase_delay_cycles_d;
   logic [7:0] next_channel_volume_code_q;
   logic [7:0] next_channel_volume_code_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       rvalid_q;
   logic       rvalid_d;
   logic       hit_q;
   logic       hit_d;
   acg_sel_t   sel;

   assign sel = decode(req_i.page, req_i.addr);

   // Register writes
   always_comb begin
      input_gain_code_d          = input_gain_code_q;
      digital_volume_code_d      = digital_volume_code_q;
      gain_trim_code_d           = gain_trim_code_q;
      phase_delay_cycles_d       = phase_delay_cycles_q;
      next_channel_volume_code_d = next_channel_volume_code_q;
      if (req_i.wr) begin
         case (sel)
            // RULE13 drop reserved bits
            ACG_SEL_GAIN: input_gain_code_d =
               req_i.wdata[`ACG_GAIN_MSB:`ACG_GAIN_LSB];
            ACG_SEL_VOLUME: digital_volume_code_d = req_i.wdata;
            ACG_SEL_TRIM: gain_trim_code_d =
               req_i.wdata[`ACG_TRIM_MSB:`ACG_TRIM_LSB];
            // RULE10 phase register write
            ACG_SEL_DELAY: phase_delay_cycles_d = req_i.wdata;
            // RULE11 next channel write
            ACG_SEL_NEXT_VOL: next_channel_volume_code_d = req_i.wdata;
            default: ;
         endcase
      end
   end

   // Read path, answered one cycle after the strobe
   always_comb begin
      rdata_d  = rdata_q;
      rvalid_d = req_i.rd;
      hit_d    = (req_i.rd || req_i.wr) && (sel != ACG_SEL_NONE);
      if (req_i.rd) begin
         case (sel)
            // RULE13 reserved reads zero
            ACG_SEL_GAIN:     rdata_d = {input_gain_code_q, 2'b00};
            // RULE5 volume readback
            ACG_SEL_VOLUME:   rdata_d = digital_volume_code_q;
            // RULE7 low nibble zero
            ACG_SEL_TRIM:     rdata_d = {gain_trim_code_q, 4'h0};
            ACG_SEL_DELAY:    rdata_d = phase_delay_cycles_q;
            ACG_SEL_NEXT_VOL: rdata_d = next_channel_volume_code_q;
            default:          rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // RULE12 gain reset
         input_gain_code_q          <= 6'h00;
         // RULE5 volume reset
         digital_volume_code_q      <= `ACG_RST_DIG_VOLUME;
         // RULE7 trim reset
         gain_trim_code_q           <= 4'h8;
         // RULE9 delay reset
         phase_delay_cycles_q       <= `ACG_RST_PHASE_DELAY;
         // RULE11 next volume reset
         next_channel_volume_code_q <= `ACG_RST_NEXT_VOLUME;
         rdata_q                    <= 8'h00;
         rvalid_q                   <= 1'b0;
         hit_q                      <= 1'b0;
      end else begin
         input_gain_code_q          <= input_gain_code_d;
         digital_volume_code_q      <= digital_volume_code_d;
         gain_trim_code_q           <= gain_trim_code_d;
         phase_delay_cycles_q       <= phase_delay_cycles_d;
         next_channel_volume_code_q <= next_channel_volume_code_d;
         rdata_q                    <= rdata_d;
         rvalid_q                   <= rvalid_d;
         hit_q                      <= hit_d;
      end
   end

   assign rdata_o  = rdata_q;
   assign rvalid_o = rvalid_q;
   assign hit_o    = hit_q;

   // Decoded settings straight from the registers
   always_comb begin
      // RULE1 gain in whole dB
      cfg_o.gain_db        = input_gain_code_q;
      // RULE2 flag codes above 42
      cfg_o.gain_reserved  = input_gain_code_q > `ACG_GAIN_MAX_CODE;
      cfg_o.volume_half_db = vol_half_db(digital_volume_code_q);
      // RULE3 zero code mutes
      cfg_o.muted = digital_volume_code_q == `ACG_VOL_MUTE_CODE;
      // RULE6 trim in tenths
      cfg_o.trim_tenth_db  = $signed({1'b0, gain_trim_code_q})
                             - $signed(`ACG_TRIM_UNITY_CODE);
      cfg_o.delay_cycles   = phase_delay_cycles_q;
   end

   // RULE11 digital mic only
   assign next_volume_half_db_o = vol_half_db(next_channel_volume_code_q);
   assign next_muted_o =
      next_channel_volume_code_q == `ACG_VOL_MUTE_CODE;
   assign next_volume_active_o  = pulse_density_mic_input_i;

   // Output sample stage; a muted channel emits true zeros
   logic [SAMPLE_W-1:0] sample_q;
   logic [SAMPLE_W-1:0] sample_d;
   logic                svalid_q;
   logic                svalid_d;

   always_comb begin
      sample_d = sample_q;
      svalid_d = sample_valid_i;
      if (sample_valid_i) begin
         // RULE3 force silence
         sample_d = cfg_o.muted ? '0 : sample_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sample_q <= '0;
         svalid_q <= 1'b0;
      end else begin
         sample_q <= sample_d;
         svalid_q <= svalid_d;
      end
   end

   assign sample_o       = sample_q;
   assign sample_valid_o = svalid_q;

   // RULE8 modulator delay line
   acg_phase_delay #(
      .DEPTH(`ACG_DELAY_DEPTH)
   ) u_delay (
      .core_clk_i    (core_clk_i),
      .rst_n_i       (rst_n_i),
      .mod_en_i      (mod_en_i),
      .bit_i         (mod_bit_i),
      .delay_cycles_i(phase_delay_cycles_q),
      .bit_o         (mod_bit_o)
   );

endmodule

// *** tb/acg_regs_sva.sv ***
/*
 * Port-level assertions for the channel gain register block.
 * Bound to acg_regs from the bench top; sees only its ports.
 */
`timescale 1ns/1ps
module acg_regs_sva
   import acg_pkg::*;
#(
   parameter int SAMPLE_W = 24
) (
   input wire logic                core_clk_i,
   input wire logic                rst_n_i,
   input wire acg_req_t            req_i,
   input wire logic [7:0]          rdata_o,
   input wire logic                rvalid_o,
   input wire logic                hit_o,
   input wire logic                mod_en_i,
   input wire logic                mod_bit_i,
   input wire logic                mod_bit_o,
   input wire logic                sample_valid_i,
   input wire logic                sample_valid_o,
   input wire logic [SAMPLE_W-1:0] sample_o,
   input wire acg_cfg_t            cfg_o,
   input wire logic                next_volume_active_o,
   input wire logic                pulse_density_mic_input_i
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_gain_reserved_flag: assert property (
      cfg_o.gain_reserved == (cfg_o.gain_db > 6'h2A))
      else $error("gain reserved flag wrong");
   a_mute_zero_out: assert property (
      sample_valid_i && cfg_o.muted && !req_i.wr
      |=> sample_valid_o && sample_o == '0)
      else $error("muted sample not zero");
   a_mute_code_link: assert property (
      cfg_o.muted == (cfg_o.volume_half_db == -9'sd201))
      else $error("mute flag and volume disagree");
   a_trim_low_zero: assert property (
      rvalid_o && hit_o && $past(req_i.addr) == 8'h4E
      |-> rdata_o[3:0] == 4'h0)
      else $error("trim low bits not zero");
   a_gain_low_zero: assert property (
      rvalid_o && hit_o && $past(req_i.addr) == 8'h4C
      |-> rdata_o[1:0] == 2'h0)
      else $error("gain low bits not zero");
   a_delay_write_lands: assert property (
      req_i.wr && req_i.page == 8'h00 && req_i.addr == 8'h4F
      |=> cfg_o.delay_cycles == $past(req_i.wdata))
      else $error("delay write not taken");
   a_zero_delay_pass: assert property (
      cfg_o.delay_cycles == 8'h00 && mod_en_i && !req_i.wr
      |=> mod_bit_o == $past(mod_bit_i))
      else $error("zero delay not transparent");
   a_other_page_read: assert property (
      req_i.rd && req_i.page != 8'h00
      |=> rvalid_o && !hit_o && rdata_o == 8'h00)
      else $error("foreign page read answered");
   a_next_vol_active: assert property (
      next_volume_active_o == pulse_density_mic_input_i)
      else $error("next volume active wrong");
endmodule

// *** tb/test_acg_regs.sv ***
/*
 * Self-checking bench for the channel gain register block.
 * Drives all inputs at the falling edge of a 200 MHz clock.
 */
`timescale 1ns/1ps
module test_acg_regs;
   import acg_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   acg_req_t          req = '0;
   logic              pulse_density_mic_input = 1'b0;
   logic              en = 1'b0;
   logic              mb = 1'b0;
   logic              sv = 1'b0;
   logic [23:0]       sd = '0;
   logic [7:0]        rdata;
   logic              rvalid;
   logic              hit;
   logic              mbo;
   logic              svo;
   logic [23:0]       so;
   acg_cfg_t          cfg;
   logic signed [8:0] nvol;
   logic              nmut;
   logic              nact;
   int                err_total = 0;
   int                num_checks = 0;
   int                cyc = 0;

   always #2.5 clk = ~clk;

   acg_regs #(.SAMPLE_W(24)) u_dut (
      .core_clk_i(clk), .rst_n_i(rst_n), .req_i(req),
      .rdata_o(rdata), .rvalid_o(rvalid), .hit_o(hit),
      .pulse_density_mic_input_i(pulse_density_mic_input), .mod_en_i(en),
      .mod_bit_i(mb), .mod_bit_o(mbo), .sample_valid_i(sv),
      .sample_i(sd), .sample_valid_o(svo), .sample_o(so),
      .cfg_o(cfg), .next_volume_half_db_o(nvol),
      .next_muted_o(nmut), .next_volume_active_o(nact));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req.wr = 1'b1;
      req.page = 8'h00;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] pg, input logic [7:0] a,
                     input logic [7:0] exp, input logic hx);
      @(negedge clk);
      req.rd = 1'b1;
      req.page = pg;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      chk(rvalid, 1'b1);
      chk(hit, hx);
      chk(rdata, exp);
   endtask

   task automatic samp(input logic [23:0] d, input logic [23:0] exp);
      @(negedge clk);
      sv = 1'b1;
      sd = d;
      @(negedge clk);
      sv = 1'b0;
      chk(svo, 1'b1);
      chk(so, exp);
   endtask

   // Earlier bits are zero only on the first pass after reset
   task automatic dly(input int n);
      logic [15:0] b;
      b = 16'hB38D;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         en = 1'b1;
         mb = b[i];
         @(negedge clk);
         en = 1'b0;
         chk(mbo, (i >= n) ? b[i-n] : 1'b0);
      end
   endtask

   task end_of_test;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         end_of_test;
      end
   end

   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      rd(8'h00, 8'h4C, 8'h00, 1'b1);
      rd(8'h00, 8'h4D, 8'hC9, 1'b1);
      rd(8'h00, 8'h4E, 8'h80, 1'b1);
      rd(8'h00, 8'h4F, 8'h00, 1'b1);
      rd(8'h00, 8'h52, 8'hC9, 1'b1);
      // Gain codes stay within 0..42; reserved low bits written as ones read back zero
      wr(8'h4C, 8'h57);
      rd(8'h00, 8'h4C, 8'h54, 1'b1);
      chk(cfg.gain_reserved, 1'b0);
      wr(8'h4C, 8'hA8);
      chk(cfg.gain_db, 6'h2A);
      chk(cfg.gain_reserved, 1'b0);
      wr(8'h4E, 8'hFF);
      rd(8'h00, 8'h4E, 8'hF0, 1'b1);
      chk({cfg.trim_tenth_db}, 5'h07);
      wr(8'h4E, 8'h00);
      chk({cfg.trim_tenth_db}, 5'h18);
      wr(8'h4D, 8'h01);
      chk({cfg.volume_half_db}, 9'h138);
      wr(8'h4D, 8'hFF);
      chk({cfg.volume_half_db}, 9'h036);
      samp(24'h5A5A5A, 24'h5A5A5A);
      wr(8'h4D, 8'h00);
      chk(cfg.muted, 1'b1);
      samp(24'h5A5A5A, 24'h000000);
      wr(8'h52, 8'h00);
      chk(nmut, 1'b1);
      chk({nvol}, 9'h137);
      pulse_density_mic_input = 1'b1;
      #1 chk(nact, 1'b1);
      rd(8'h00, 8'h50, 8'h00, 1'b0);
      rd(8'h01, 8'h4D, 8'h00, 1'b0);
      wr(8'h4F, 8'h03);
      dly(3);
      wr(8'h4F, 8'h00);
      dly(0);
      // Mid-run reset must restore the volume written to zero above
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      rd(8'h00, 8'h4D, 8'hC9, 1'b1);
      end_of_test;
   end
endmodule

bind acg_regs acg_regs_sva #(.SAMPLE_W(SAMPLE_W)) u_sva (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
   .rdata_o(rdata_o), .rvalid_o(rvalid_o), .hit_o(hit_o),
   .mod_en_i(mod_en_i), .mod_bit_i(mod_bit_i), .mod_bit_o(mod_bit_o),
   .sample_valid_i(sample_valid_i), .sample_valid_o(sample_valid_o),
   .sample_o(sample_o), .cfg_o(cfg_o),
   .next_volume_active_o(next_volume_active_o),
   .pulse_density_mic_input_i(pulse_density_mic_input_i));
